// ==== logic/smcl_pkg.sv ====
`default_nettype none
package smcl_pkg;
    // line levels: mark is logic high on the digital side of the drivers
    localparam logic LINE_MARK = 1'b1;
    localparam logic LINE_SPACE = 1'b0;
    localparam int CLK_HZ = 20_000_000;
    localparam int DROP_MS = 3500;
    localparam int DROP_CYCLES = (CLK_HZ / 1000) * DROP_MS;
    localparam int CNT_W = 27;
    localparam logic [CNT_W-1:0] CNT_RESET = 27'h000_0000;
endpackage : smcl_pkg
`default_nettype wire

// ==== logic/smcl_lines.sv ====
// Notes on behaviour
// - transmit and receive run independently, full duplex
// - idle transmit line sits at mark
// - request-to-send always asserted
// - terminal ready dropped in local mode
// - long break drops terminal ready 3.5 s
// - speed-select outputs always asserted
// - modem status inputs ignored entirely
// - mark unasserted, space asserted everywhere
// - open input reads as mark
`timescale 1ns/1ps
`default_nettype none
module smcl_lines #(
    parameter int DROP_CYCLES = smcl_pkg::DROP_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic tx_busy,
    input wire logic tx_bit,
    input wire logic rxd_pin,
    input wire logic local_mode,
    input wire logic long_break,
    input wire logic cts_pin,
    input wire logic dsr_pin,
    input wire logic dcd_pin,
    input wire logic spd_ind_pin,
    input wire logic txc_pin,
    input wire logic rxc_pin,
    input wire logic ri_pin,
    output logic txd_pin,
    output logic rts_pin,
    output logic dtr_pin,
    output logic spd_sel_pin,
    output logic rx_bit
);
    logic rx_meta;
    logic rx_sync;
    logic [smcl_pkg::CNT_W-1:0] drop_cnt;
    logic dropping;
    logic unused_in;

    localparam logic [smcl_pkg::CNT_W-1:0] DROP_LOAD =
        DROP_CYCLES[smcl_pkg::CNT_W-1:0];
    localparam logic [smcl_pkg::CNT_W-1:0] CNT_LAST = 27'h000_0001;

    // drop timer still counting
    function automatic logic smcl_running(
        input logic [smcl_pkg::CNT_W-1:0] cnt
    );
        return cnt != smcl_pkg::CNT_RESET;
    endfunction : smcl_running

    assign unused_in = cts_pin ^
                       dsr_pin ^
                       dcd_pin ^
                       spd_ind_pin ^
                       txc_pin ^
                       rxc_pin ^
                       ri_pin;

    // reset to mark, board pull-up keeps open line at mark
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rx_meta <= smcl_pkg::LINE_MARK;
            rx_sync <= smcl_pkg::LINE_MARK;
        end else begin
            rx_meta <= rxd_pin;
            rx_sync <= rx_meta;
        end
    end

    // receive path separate from transmit path
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rx_bit <= smcl_pkg::LINE_MARK;
        end else begin
            rx_bit <= rx_sync;
        end
    end

    // mark unless a character is in flight
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            txd_pin <= smcl_pkg::LINE_MARK;
        end else begin
            txd_pin <= tx_busy ? tx_bit : smcl_pkg::LINE_MARK;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            drop_cnt <= smcl_pkg::CNT_RESET;
        end else if (long_break) begin
            drop_cnt <= DROP_LOAD;
        end else if (smcl_running(drop_cnt)) begin
            drop_cnt <= drop_cnt - 1'b1;
        end
    end
    assign dropping = smcl_running(drop_cnt);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            dtr_pin <= smcl_pkg::LINE_MARK;
        end else begin
            dtr_pin <= (local_mode || long_break || dropping) ?
                       smcl_pkg::LINE_MARK : smcl_pkg::LINE_SPACE;
        end
    end

    assign rts_pin = smcl_pkg::LINE_SPACE;
    assign spd_sel_pin = smcl_pkg::LINE_SPACE;

    chk_rts_space: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        rts_pin == smcl_pkg::LINE_SPACE
    ) else $error("rts not asserted");

    chk_spd_space: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        spd_sel_pin == smcl_pkg::LINE_SPACE
    ) else $error("spd not set");

    chk_rts_reset: assert property (
        @(posedge core_clk)
        (rts_pin == smcl_pkg::LINE_SPACE) &&
        (spd_sel_pin == smcl_pkg::LINE_SPACE)
    ) else $error("rts or spd dropped in reset");

    chk_tx_idle: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !tx_busy |=> txd_pin == smcl_pkg::LINE_MARK
    ) else $error("txd not mark when idle");

    chk_tx_data: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        tx_busy |=> txd_pin == $past(tx_bit)
    ) else $error("txd not following data");

    chk_tx_space: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        tx_busy && !tx_bit |=> txd_pin == smcl_pkg::LINE_SPACE
    ) else $error("txd space bit lost");

    chk_txd_exact: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        $past(rst_n) |-> txd_pin ==
            ($past(tx_busy) ? $past(tx_bit) : smcl_pkg::LINE_MARK)
    ) else $error("txd gated by other lines");

    chk_dtr_local: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        local_mode |=> dtr_pin == smcl_pkg::LINE_MARK
    ) else $error("dtr asserted in local");

    chk_dtr_break: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        long_break |=> (dtr_pin == smcl_pkg::LINE_MARK) [*8]
    ) else $error("dtr up during drop");

    chk_dtr_hold: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        dropping |=> dtr_pin == smcl_pkg::LINE_MARK
    ) else $error("dtr up while timer runs");

    chk_drop_end: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        drop_cnt == CNT_LAST && !long_break |=> !dropping
    ) else $error("drop timer overran");

    chk_drop_load: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        long_break |=> drop_cnt == DROP_LOAD
    ) else $error("drop timer not restarted");

    chk_drop_count: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        dropping && !long_break |=> drop_cnt == $past(drop_cnt) - 1'b1
    ) else $error("drop timer skipped a step");

    chk_dtr_back: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !local_mode && !long_break && !dropping
        |=> dtr_pin == smcl_pkg::LINE_SPACE
    ) else $error("dtr not reasserted");

    chk_dtr_exact: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        $past(rst_n) |-> dtr_pin ==
            (($past(local_mode) || $past(long_break) || $past(dropping)) ?
            smcl_pkg::LINE_MARK : smcl_pkg::LINE_SPACE)
    ) else $error("dtr gated by other lines");

    chk_rx_path: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        rx_bit == $past(rxd_pin, 3) || $past(!rst_n, 3)
    ) else $error("rx path latency wrong");

    chk_rx_open: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        rxd_pin [*3] |=> rx_bit == smcl_pkg::LINE_MARK
    ) else $error("open rx not idle");

    chk_rx_space: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !rxd_pin [*3] |=> rx_bit == smcl_pkg::LINE_SPACE
    ) else $error("rx space bit lost");

    chk_reset_marks: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        $rose(rst_n) |-> txd_pin == smcl_pkg::LINE_MARK &&
            dtr_pin == smcl_pkg::LINE_MARK && rx_bit == smcl_pkg::LINE_MARK
    ) else $error("lines not mark after reset");

    cov_break: cover property (@(posedge core_clk) long_break);
    cov_drop_end: cover property (@(posedge core_clk)
        $fell(dropping));
    cov_rebreak: cover property (@(posedge core_clk)
        dropping && long_break);
    cov_local: cover property (@(posedge core_clk) local_mode);
    cov_tx: cover property (@(posedge core_clk) tx_busy ##1 !tx_busy);
endmodule : smcl_lines
`default_nettype wire

// ==== testbench/smcl_modem.sv ====
`timescale 1ns/1ps
`default_nettype none
module smcl_modem (
    input wire logic core_clk,
    input wire logic rx_en,
    input wire logic rx_val,
    output logic rxd_pin,
    output logic [6:0] stat
);
    assign rxd_pin = rx_en ? rx_val : 1'b1;
    always @(posedge core_clk) stat <= (stat == 7'h55) ? 7'h2a : 7'h55;
endmodule : smcl_modem
`default_nettype wire

// ==== testbench/test_serial_modem_control_lines.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_serial_modem_control_lines;
    logic core_clk = 0, rst_n = 0, tx_busy = 0, tx_bit = 1, long_break = 0;
    logic local_mode = 0, rx_en = 0, rx_val = 1, rxd_pin, txd_pin, rts_pin;
    logic dtr_pin, spd_sel_pin, rx_bit;
    logic [6:0] stat;
    int mismatches = 0, tests_run = 0;
    always #25 core_clk = ~core_clk;
    smcl_modem smcl_modem_inst (.core_clk(core_clk), .rx_en(rx_en),
        .rx_val(rx_val), .rxd_pin(rxd_pin), .stat(stat));
    smcl_lines #(.DROP_CYCLES(20)) smcl_lines_inst (.core_clk(core_clk),
        .rst_n(rst_n), .tx_busy(tx_busy), .tx_bit(tx_bit), .rxd_pin(rxd_pin),
        .local_mode(local_mode), .long_break(long_break), .cts_pin(stat[0]),
        .dsr_pin(stat[1]), .dcd_pin(stat[2]), .spd_ind_pin(stat[3]),
        .txc_pin(stat[4]), .rxc_pin(stat[5]), .ri_pin(stat[6]),
        .txd_pin(txd_pin), .rts_pin(rts_pin), .dtr_pin(dtr_pin),
        .spd_sel_pin(spd_sel_pin), .rx_bit(rx_bit));
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask : cyc
    task automatic chk(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t line level wrong", $time);
        end
    endtask : chk
    task automatic t_duplex;
        chk(rts_pin, smcl_pkg::LINE_SPACE);
        chk(spd_sel_pin, smcl_pkg::LINE_SPACE);
        chk(dtr_pin, smcl_pkg::LINE_SPACE);
        tx_busy = 1;
        tx_bit = 0;
        rx_en = 1;
        rx_val = 0;
        cyc(4);
        chk(txd_pin, smcl_pkg::LINE_SPACE);
        chk(rx_bit, smcl_pkg::LINE_SPACE);
        rx_en = 0;
        tx_busy = 0;
        cyc(4);
        chk(rx_bit, smcl_pkg::LINE_MARK);
        chk(txd_pin, smcl_pkg::LINE_MARK);
        $display("duplex done");
    endtask : t_duplex
    task automatic t_break;
        long_break = 1;
        cyc(1);
        long_break = 0;
        cyc(10);
        // second break inside the drop, timer must restart
        long_break = 1;
        cyc(1);
        long_break = 0;
        cyc(20);
        chk(dtr_pin, smcl_pkg::LINE_MARK);
        cyc(1);
        chk(dtr_pin, smcl_pkg::LINE_SPACE);
        local_mode = 1;
        cyc(2);
        chk(dtr_pin, smcl_pkg::LINE_MARK);
        local_mode = 0;
        cyc(2);
        chk(dtr_pin, smcl_pkg::LINE_SPACE);
        $display("break done");
    endtask : t_break
    task automatic stop_test;
        $display("checks %0d bad %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : stop_test
    initial begin
        cyc(6);
        rst_n = 1;
        cyc(2);
        t_duplex();
        t_break();
        stop_test();
    end
    initial begin
        #50000;
        mismatches++;
        stop_test();
    end
endmodule : test_serial_modem_control_lines
`default_nettype wire
